// ---- clt_pkg.sv ----
package clt_pkg;
	// register byte addresses (printed offsets not multiples of four: index * 4)
	localparam logic [7:0] CLT_IDX_UPPER = 8'h12;
	localparam logic [7:0] CLT_IDX_LOWER = 8'h13;
	localparam logic [7:0] CLT_IDX_SETUP = 8'h14;
	localparam logic [7:0] CLT_IDX_STATUS = 8'h15;
	localparam logic [11:0] CLT_ADDR_UPPER = {2'b00, CLT_IDX_UPPER, 2'b00};
	localparam logic [11:0] CLT_ADDR_LOWER = {2'b00, CLT_IDX_LOWER, 2'b00};
	localparam logic [11:0] CLT_ADDR_SETUP = {2'b00, CLT_IDX_SETUP, 2'b00};
	localparam logic [11:0] CLT_ADDR_STATUS = {2'b00, CLT_IDX_STATUS, 2'b00};
	// reset values
	localparam logic [7:0] CLT_RST_UPPER = 8'h80;
	localparam logic [7:0] CLT_RST_LOWER = 8'h00;
	localparam logic [1:0] CLT_RST_HELD = 2'h3;
	// setup register fields
	localparam int CLT_TRIG_BIT = 0;
	localparam int CLT_HELD_LSB = 6;
	// default measurement time in cycles
	localparam int CLT_MEAS_CYCLES = 1000;
	typedef enum logic [1:0] {CLT_IDLE, CLT_BUSY, CLT_DONE} clt_meas_e;
endpackage

// ---- clt_apb_decode.sv ----
`timescale 1ns/10ps
`default_nettype none
// apb address decode: one-hot select per register, plus mapped flag
module clt_apb_decode
	import clt_pkg::*;
(
	input wire logic [11:0] paddr,
	output logic sel_upper,
	output logic sel_lower,
	output logic sel_setup,
	output logic sel_status,
	output logic mapped
);
	// word match: low two address bits ignored, every register is a word
	function automatic logic word_hit(input logic [11:0] a, input logic [11:0] base);
		return a[11:2] == base[11:2];
	endfunction

	assign sel_upper = word_hit(paddr, CLT_ADDR_UPPER);
	assign sel_lower = word_hit(paddr, CLT_ADDR_LOWER);
	assign sel_setup = word_hit(paddr, CLT_ADDR_SETUP);
	assign sel_status = word_hit(paddr, CLT_ADDR_STATUS);
	assign mapped = sel_upper | sel_lower | sel_setup | sel_status;
endmodule
`default_nettype wire

// ---- clt_meas_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
// measurement sequencer: runs a fixed-length measurement when started
module clt_meas_ctrl
	import clt_pkg::*;
#(
	parameter int MEAS_CYCLES = CLT_MEAS_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	output logic busy,
	output logic done
);
	clt_meas_e state_q, state_d;
	logic [31:0] cnt_q, cnt_d;
	logic [31:0] last;

	assign last = 32'(MEAS_CYCLES - 1);

	// next-state: count the measurement window, one-cycle done pulse
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		unique case (state_q)
			CLT_IDLE: begin
				cnt_d = '0;
				if (start) begin
					state_d = CLT_BUSY;
				end
			end
			CLT_BUSY: begin
				cnt_d = cnt_q + 32'h1;
				if (cnt_q >= last) begin
					state_d = CLT_DONE;
				end
			end
			CLT_DONE: begin
				state_d = CLT_IDLE;
				cnt_d = '0;
			end
			default: begin
				state_d = CLT_IDLE;
				cnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= CLT_IDLE;
			cnt_q <= '0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	assign busy = state_q == CLT_BUSY;
	assign done = state_q == CLT_DONE;
endmodule
`default_nettype wire

// ---- clt_regs.sv ----
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module clt_regs
	import clt_pkg::*;
#(
	parameter int MEAS_CYCLES = CLT_MEAS_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] cold_limit,
	output logic meas_busy,
	output logic meas_done
);
	logic [7:0] upper_q;
	logic [7:0] lower_q;
	logic trig_q;
	logic trig_d;
	logic done_seen_q;
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic sel_upper, sel_lower, sel_setup, sel_status, mapped;
	logic access, wr, rd, lane0;
	logic start_meas, meas_end, busy;
	logic [7:0] setup_rd;
	logic [31:0] rd_mux;

	clt_apb_decode u_dec (
		.paddr(paddr),
		.sel_upper(sel_upper),
		.sel_lower(sel_lower),
		.sel_setup(sel_setup),
		.sel_status(sel_status),
		.mapped(mapped)
	);

	clt_meas_ctrl #(.MEAS_CYCLES(MEAS_CYCLES)) u_meas (
		.pclk(pclk),
		.presetn(presetn),
		.start(start_meas),
		.busy(busy),
		.done(meas_end)
	);

	// zero-wait slave: every access completes in its first access cycle
	assign pready = 1'b1;
	assign access = psel & penable;
	assign lane0 = pstrb[0];
	assign wr = access & pwrite & lane0;
	assign rd = access & ~pwrite;

	// a write of one to the trigger starts the engine only when idle
	assign start_meas = wr & sel_setup & pwdata[CLT_TRIG_BIT] & ~trig_q;

	// completion clears the trigger and wins over a same-cycle write of zero;
	// a write of zero while busy is ignored so the bit keeps tracking progress
	always_comb begin
		trig_d = trig_q;
		if (start_meas) begin
			trig_d = 1'b1;
		end
		if (meas_end) begin
			trig_d = 1'b0;
		end
	end

	// held bits are constant; software is expected to write 0b11 there
	assign setup_rd = {CLT_RST_HELD, 5'h00, trig_q};

	// read data selection, unmapped reads return zero; a completion in the
	// capture cycle is shown at once, else the access-cycle clear would lose it
	assign rd_mux = sel_upper ? {24'h0, upper_q} :
		sel_lower ? {24'h0, lower_q} :
		sel_setup ? {24'h0, setup_rd} :
		sel_status ? {30'h0, done_seen_q | meas_end, busy} :
		32'h0;

	// threshold bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_q <= CLT_RST_UPPER;
			lower_q <= CLT_RST_LOWER;
		end else begin
			if (wr & sel_upper) begin
				upper_q <= pwdata[7:0];
			end
			if (wr & sel_lower) begin
				lower_q <= pwdata[7:0];
			end
		end
	end

	// trigger and sticky completion flag; set wins over a read-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_q <= 1'b0;
			done_seen_q <= 1'b0;
		end else begin
			trig_q <= trig_d;
			if (meas_end) begin
				done_seen_q <= 1'b1;
			end else if (rd & sel_status) begin
				done_seen_q <= 1'b0;
			end
		end
	end

	// registered read data and error for unmapped addresses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
			pslverr_q <= 1'b0;
		end else begin
			if (psel & ~penable) begin
				prdata_q <= rd_mux;
				pslverr_q <= ~mapped;
			end
		end
	end

	assign prdata = prdata_q;
	assign pslverr = pslverr_q & access;
	assign cold_limit = {upper_q, lower_q};
	assign meas_busy = trig_q;
	assign meas_done = meas_end;
endmodule
`default_nettype wire

// ---- clt_regs_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module clt_regs_monitor
	import clt_pkg::*;
#(
	parameter int MEAS_CYCLES = CLT_MEAS_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [15:0] cold_limit,
	input wire logic meas_busy,
	input wire logic meas_done
);
	// accepted low-lane write, and setup-cycle read of the setup register
	wire wr = psel && penable && pready && pwrite && pstrb[0];
	wire rd_su = psel && !penable && !pwrite && paddr[11:2] == {2'b00, CLT_IDX_SETUP};
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	upper_write_a: assert property (
		wr && paddr[11:2] == {2'b00, CLT_IDX_UPPER} |=> cold_limit[15:8] == $past(pwdata[7:0])
	) else $error("upper write lost");
	lower_write_a: assert property (
		wr && paddr[11:2] == {2'b00, CLT_IDX_LOWER} |=> cold_limit[7:0] == $past(pwdata[7:0])
	) else $error("lower write lost");
	held_read_a: assert property (
		rd_su |=> prdata[7:6] == 2'b11 && prdata[0] == $past(meas_busy)
	) else $error("setup readback");
	trig_start_a: assert property (
		wr && paddr[11:2] == {2'b00, CLT_IDX_SETUP} && pwdata[0] && !meas_busy |=> meas_busy
	) else $error("trigger not set");
	trig_clear_a: assert property (
		meas_done |-> meas_busy ##1 !meas_busy
	) else $error("trigger not cleared");
endmodule
bind clt_regs clt_regs_monitor #(.MEAS_CYCLES(MEAS_CYCLES)) u_mon (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .cold_limit,
	.meas_busy, .meas_done);
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
	import clt_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, done, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [15:0] lim;
	logic [7:0] u, l;
	int fail_count, n_checks, n_done;
	// short measurement keeps the poll loop brief
	clt_regs #(.MEAS_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cold_limit(lim),
		.meas_busy(busy), .meas_done(done));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// completion pulses counted as they stand, one per finished measurement
	always @(posedge pclk) begin
		if (done === 1'b1) begin
			n_done++;
		end
	end
	// setup readback: held bits fixed, trigger shows progress
	function automatic logic [31:0] exp_setup(input logic trig);
		return {24'h0, CLT_RST_HELD, 5'h00, trig};
	endfunction
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// request held until pready is sampled high, then released
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && i < 8) begin
			i++;
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			fail_count++;
			results();
		end
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata} <= '0;
		pstrb <= 4'hf;
		presetn <= 1'b0;
		void'($urandom(57924));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, CLT_ADDR_UPPER, 0);
		chk("upper", rd, 32'h80);
		apb(0, CLT_ADDR_LOWER, 0);
		chk("lower", rd, 32'h0);
		apb(0, CLT_ADDR_SETUP, 0);
		chk("setup", rd, exp_setup(1'b0));
		$display("reset test done");
		// all-ones/zero corner first, then random bytes with junk upper lanes
		for (int k = 0; k < 6; k++) begin
			u = (k == 0) ? 8'hff : 8'($urandom);
			l = (k == 0) ? 8'h00 : 8'($urandom);
			apb(1, CLT_ADDR_UPPER, {24'($urandom), u});
			apb(1, CLT_ADDR_LOWER, {24'($urandom), l});
			apb(0, CLT_ADDR_UPPER, 0);
			chk("upper", rd, {24'h0, u});
			chk("limit", {16'h0, lim}, {16'h0, u, l});
		end
		// a write without the low lane strobe must leave the byte alone
		pstrb <= 4'he;
		apb(1, CLT_ADDR_UPPER, {24'h0, ~u});
		pstrb <= 4'hf;
		chk("masked", {16'h0, lim}, {16'h0, u, l});
		$display("threshold test done");
		// reset in mid-run brings the threshold back to its defaults
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk("limit reset", {16'h0, lim}, {16'h0, CLT_RST_UPPER, CLT_RST_LOWER});
		$display("reset test done");
		// software always puts 0b11 into the held bits
		apb(1, CLT_ADDR_SETUP, 32'hc1);
		apb(0, CLT_ADDR_SETUP, 0);
		chk("busy", rd, exp_setup(1'b1));
		for (int k = 0; k < 20 && rd[0]; k++) apb(0, CLT_ADDR_SETUP, 0);
		chk("idle", rd, exp_setup(1'b0));
		apb(0, CLT_ADDR_STATUS, 0);
		chk("status", rd, 32'h2);
		// second run: the status read is captured in the completion cycle
		apb(1, CLT_ADDR_SETUP, 32'hc1);
		apb(0, 12'hffc, 0);
		chk("slverr", {31'h0, err}, 32'h1);
		chk("unmapped", rd, 32'h0);
		chk("busy pin", {31'h0, busy}, 32'h1);
		apb(0, CLT_ADDR_STATUS, 0);
		chk("done seen", rd, 32'h2);
		apb(0, CLT_ADDR_STATUS, 0);
		chk("done cleared", rd, 32'h0);
		chk("done pulses", 32'(n_done), 32'h2);
		chk("idle pin", {31'h0, busy}, 32'h0);
		$display("trigger test done");
		results();
	end
endmodule
`default_nettype wire
